// *** verilog/tcm_pkg.sv ***
// constants and types shared by the timer channel mode block
`default_nettype none

package tcm_pkg;

   // register data and address widths
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hC;

   // mode register fields (output and input views share bits)
   localparam int MODE_W      = 8;
   localparam int MODE_DIR_LO = 0;
   localparam int MODE_IMM    = 2;
   localparam int MODE_PRE    = 3;
   localparam int MODE_OCT_LO = 4;
   localparam int MODE_DIV_LO = 2;
   localparam int MODE_DF_LO  = 4;

   // channel control register fields
   localparam int CTRL_EN  = 0;
   localparam int CTRL_POL = 1;
   localparam int CTRL_CP  = 3;

   // status register fields
   localparam int STAT_RAW    = 0;
   localparam int STAT_FILT   = 1;
   localparam int STAT_CNT_LO = 2;

   // reset values
   localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
   localparam logic [3:0]        CTRL_RST = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // direction codes
   localparam logic [1:0] DIR_OUT = 2'b00;
   localparam logic [1:0] DIR_IN  = 2'b01;

   // output control codes
   localparam logic [2:0] OC_OFF    = 3'b000;
   localparam logic [2:0] OC_HI_M   = 3'b001;
   localparam logic [2:0] OC_LO_M   = 3'b010;
   localparam logic [2:0] OC_TOG    = 3'b011;
   localparam logic [2:0] OC_F_LO   = 3'b100;
   localparam logic [2:0] OC_F_HI   = 3'b101;
   localparam logic [2:0] OC_PWM_A  = 3'b110;
   localparam logic [2:0] OC_PWM_B  = 3'b111;

   // active edge selection {complementary, polarity}
   localparam logic [1:0] EDGE_RISE = 2'b00;
   localparam logic [1:0] EDGE_FALL = 2'b01;
   localparam logic [1:0] EDGE_BOTH = 2'b11;

   // capture prescaler limits (edges minus one)
   localparam logic [2:0] PSC_LIM1 = 3'h0;
   localparam logic [2:0] PSC_LIM2 = 3'h1;
   localparam logic [2:0] PSC_LIM4 = 3'h3;
   localparam logic [2:0] PSC_LIM8 = 3'h7;

   // filter setting: sample source, base clock divide, run length
   typedef struct packed {
      logic       use_int;
      logic [5:0] div;
      logic [3:0] n;
   } tcm_filt_t;

   function automatic tcm_filt_t tcm_filt_cfg(input logic [3:0] code);
      tcm_filt_t f;
      f = '{use_int: 1'b0, div: 6'h01, n: 4'h1};
      unique case (code)
         4'h0: f = '{1'b0, 6'h01, 4'h1};
         4'h1: f = '{1'b1, 6'h01, 4'h2};
         4'h2: f = '{1'b1, 6'h01, 4'h4};
         4'h3: f = '{1'b1, 6'h01, 4'h8};
         4'h4: f = '{1'b0, 6'h02, 4'h6};
         4'h5: f = '{1'b0, 6'h02, 4'h8};
         4'h6: f = '{1'b0, 6'h04, 4'h6};
         4'h7: f = '{1'b0, 6'h04, 4'h8};
         4'h8: f = '{1'b0, 6'h08, 4'h6};
         4'h9: f = '{1'b0, 6'h08, 4'h8};
         4'hA: f = '{1'b0, 6'h10, 4'h5};
         4'hB: f = '{1'b0, 6'h10, 4'h6};
         4'hC: f = '{1'b0, 6'h10, 4'h8};
         4'hD: f = '{1'b0, 6'h20, 4'h5};
         4'hE: f = '{1'b0, 6'h20, 4'h6};
         4'hF: f = '{1'b0, 6'h20, 4'h8};
      endcase
      return f;
   endfunction

endpackage

`default_nettype wire

// *** verilog/tcm_input_filter.sv ***
// run-length digital filter for the channel input
`timescale 1ns/100ps
`default_nettype none

module tcm_input_filter #(
   parameter int N_W = 4
) (
   // clock and reset
   input  wire logic           mclk,
   input  wire logic           arst_n,
   // sampling control
   input  wire logic           sample_en,
   input  wire logic [N_W-1:0] n_needed,
   // data
   input  wire logic           din,
   output var  logic           dout
);

   logic           level_reg;
   logic           level_next;
   logic [N_W-1:0] run_reg;
   logic [N_W-1:0] run_next;

   if (N_W < 4) begin : g_chk
      $error("tcm_input_filter: N_W must hold a run of 8");
   end

   // a new level passes only after n_needed equal samples in a row
   always_comb begin
      level_next = level_reg;
      run_next   = run_reg;
      if (sample_en) begin
         if (din == level_reg) begin
            run_next = '0;                     // glitch ends the run
         end else if (run_reg + 1'b1 >= n_needed) begin
            level_next = din;
            run_next   = '0;
         end else begin
            run_next = run_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         level_reg <= 1'b0;
         run_reg   <= '0;
      end else begin
         level_reg <= level_next;
         run_reg   <= run_next;
      end
   end

   assign dout = level_reg;

endmodule // tcm_input_filter

`default_nettype wire

// *** verilog/tcm_channel.sv ***
// timer channel 1 mode logic: compare output, input filter and capture
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - On an enabled output channel, any output control code other than disconnected drives the channel output from the raw output, modified by polarity.
// - With compare preload off, a written compare value is used by the comparator at once.
// - With compare preload on, a written value waits in a shadow and moves to the active value on overflow.
// - With immediate output off, PWM modes change the output only through the counter versus compare result.
// - With immediate output on in a PWM mode, a trigger drives the output at once without the compare.
// - Direction code 00 makes the channel an output, 01 an input from the filtered input; 10 and 11 are reserved.
// - The filter passes a new input level only after N consecutive equal samples.
// - Filter code 0000 does no filtering at the base rate; codes 0001 to 0011 sample at the timer clock with N of 2, 4, 8.
// - Filter codes 0100 to 1001 sample at base clock over 2, 2, 4, 4, 8, 8 with N alternating 6 and 8.
// - Filter codes 1010 to 1100 sample at base over 16 and 1101 to 1111 at base over 32, N of 5, 6, 8.
// - Prescaler codes 00 to 11 capture on every 1st, 2nd, 4th or 8th active edge.
// - The prescaler edge count is cleared while the channel is disabled.
// - In output mode polarity 0 keeps the output active high and 1 makes it active low.
// - With the channel disabled, not in output direction or on output control code 000 the output is held at 0, else it is the raw output after polarity.
module tcm_channel
   import tcm_pkg::*;
#(
   parameter int DTS_DIV = 1
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              arst_n,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output var  logic [DATA_W-1:0] rdata,
   // counter side
   input  wire logic [DATA_W-1:0] cnt_value,
   input  wire logic              cnt_down,
   input  wire logic              ovf_event,
   input  wire logic              trig_event,
   // pins and capture result
   input  wire logic              ch1_input,
   output var  logic              ch1_output,
   output var  logic              capture_pulse
);

   if (DTS_DIV < 1 || DTS_DIV > 255) begin : g_chk
      $error("tcm_channel: DTS_DIV must lie in 1..255");
   end

   // registers
   logic [MODE_W-1:0] mode_reg;
   logic [MODE_W-1:0] mode_next;
   logic [3:0]        ctrl_reg;
   logic [3:0]        ctrl_next;
   logic [DATA_W-1:0] shadow_reg;
   logic [DATA_W-1:0] shadow_next;
   logic [DATA_W-1:0] active_reg;
   logic [DATA_W-1:0] active_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   // decoded fields
   logic [1:0] dir;
   logic       imm_en;
   logic       pre_en;
   logic [2:0] oc_code;
   logic [1:0] psc_code;
   logic [3:0] df_code;
   logic       ch_en;
   logic       pol;
   logic [1:0] edge_sel;
   logic       is_out;
   logic       is_in;

   assign dir      = mode_reg[MODE_DIR_LO +: 2];
   assign imm_en   = mode_reg[MODE_IMM];
   assign pre_en   = mode_reg[MODE_PRE];
   assign oc_code  = mode_reg[MODE_OCT_LO +: 3];
   assign psc_code = mode_reg[MODE_DIV_LO +: 2];
   assign df_code  = mode_reg[MODE_DF_LO +: 4];
   assign ch_en    = ctrl_reg[CTRL_EN];
   assign pol      = ctrl_reg[CTRL_POL];
   assign edge_sel = {ctrl_reg[CTRL_CP], ctrl_reg[CTRL_POL]};
   assign is_out   = (dir == DIR_OUT);
   assign is_in    = (dir == DIR_IN);         // reserved codes do neither

   // input synchroniser, base clock divider, sample divider
   logic       sync1_reg;
   logic       sync2_reg;
   logic [7:0] dts_cnt_reg;
   logic [7:0] dts_cnt_next;
   logic [5:0] smp_cnt_reg;
   logic [5:0] smp_cnt_next;
   logic       dts_tick;
   logic       sample_en;
   tcm_filt_t  fcfg;
   logic       filt_level;

   assign fcfg     = tcm_filt_cfg(df_code);
   assign dts_tick = (dts_cnt_reg == 8'(DTS_DIV - 1));

   // the base clock is a tick on mclk, so the filter needs no second domain
   always_comb begin
      dts_cnt_next = dts_tick ? 8'h00 : dts_cnt_reg + 8'h01;
      smp_cnt_next = smp_cnt_reg;
      sample_en    = 1'b0;
      if (fcfg.use_int) begin
         sample_en    = 1'b1;
         smp_cnt_next = 6'h00;
      end else if (dts_tick) begin
         if (smp_cnt_reg >= fcfg.div - 6'h01) begin
            sample_en    = 1'b1;
            smp_cnt_next = 6'h00;
         end else begin
            smp_cnt_next = smp_cnt_reg + 6'h01;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg   <= 1'b0;
         sync2_reg   <= 1'b0;
         dts_cnt_reg <= 8'h00;
         smp_cnt_reg <= 6'h00;
      end else begin
         sync1_reg   <= ch1_input;
         sync2_reg   <= sync1_reg;
         dts_cnt_reg <= dts_cnt_next;
         smp_cnt_reg <= smp_cnt_next;
      end
   end

   tcm_input_filter #(
      .N_W       (4)
   ) u_filter (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .sample_en (sample_en),
      .n_needed  (fcfg.n),
      .din       (sync2_reg),
      .dout      (filt_level)
   );

   // edge detect and capture prescaler
   logic       filt_prev_reg;
   logic [2:0] psc_cnt_reg;
   logic [2:0] psc_cnt_next;
   logic       cap_reg;
   logic       cap_next;
   logic       act_edge;
   logic [2:0] psc_lim;

   always_comb begin
      unique case (edge_sel)
         EDGE_RISE: act_edge = filt_level & ~filt_prev_reg;
         EDGE_FALL: act_edge = ~filt_level & filt_prev_reg;
         EDGE_BOTH: act_edge = filt_level ^ filt_prev_reg;
         default:   act_edge = 1'b0;          // reserved edge code
      endcase
   end

   always_comb begin
      unique case (psc_code)
         2'b00: psc_lim = PSC_LIM1;
         2'b01: psc_lim = PSC_LIM2;
         2'b10: psc_lim = PSC_LIM4;
         2'b11: psc_lim = PSC_LIM8;
      endcase
   end

   // only filtered edges of the chosen sense count toward a capture
   always_comb begin
      psc_cnt_next = psc_cnt_reg;
      cap_next     = 1'b0;
      if (!ch_en) begin
         psc_cnt_next = 3'h0;
      end else if (is_in && act_edge) begin
         if (psc_cnt_reg >= psc_lim) begin
            cap_next     = 1'b1;
            psc_cnt_next = 3'h0;
         end else begin
            psc_cnt_next = psc_cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         filt_prev_reg <= 1'b0;
         psc_cnt_reg   <= 3'h0;
         cap_reg       <= 1'b0;
      end else begin
         filt_prev_reg <= filt_level;
         psc_cnt_reg   <= psc_cnt_next;
         cap_reg       <= cap_next;
      end
   end

   // register writes, compare preload and capture store
   logic wr_mode;
   logic wr_ctrl;
   logic wr_data;

   assign wr_mode = wr_stb && (addr == ADDR_MODE);
   assign wr_ctrl = wr_stb && (addr == ADDR_CTRL);
   assign wr_data = wr_stb && (addr == ADDR_DATA);

   // capture wins over a same-cycle write so no event is lost
   always_comb begin
      mode_next   = wr_mode ? wdata[MODE_W-1:0] : mode_reg;
      ctrl_next   = ctrl_reg;
      shadow_next = shadow_reg;
      active_next = active_reg;
      if (wr_ctrl) begin
         ctrl_next[CTRL_EN]  = wdata[CTRL_EN];
         ctrl_next[CTRL_POL] = wdata[CTRL_POL];
         ctrl_next[CTRL_CP]  = wdata[CTRL_CP];
      end
      if (wr_data) begin
         shadow_next = wdata;
         if (!pre_en) begin
            active_next = wdata;
         end
      end
      if (pre_en && ovf_event && is_out) begin
         active_next = shadow_reg;
      end
      if (cap_next) begin
         active_next = cnt_value;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg   <= MODE_RST;
         ctrl_reg   <= CTRL_RST;
         shadow_reg <= DATA_RST;
         active_reg <= DATA_RST;
      end else begin
         mode_reg   <= mode_next;
         ctrl_reg   <= ctrl_next;
         shadow_reg <= shadow_next;
         active_reg <= active_next;
      end
   end

   // raw compare output
   logic raw_reg;
   logic raw_next;
   logic hold_reg;
   logic hold_next;
   logic match;
   logic pwm;
   logic pwm_a_lvl;
   logic out_reg;
   logic out_next;

   assign match = (cnt_value == active_reg);
   assign pwm   = (oc_code == OC_PWM_A) || (oc_code == OC_PWM_B);

   // pwm A level per count direction, pwm B is its inverse
   always_comb begin
      if (cnt_down) begin
         pwm_a_lvl = !(active_reg < cnt_value);
      end else begin
         pwm_a_lvl = (active_reg > cnt_value);
      end
   end

   // a trigger forces the active level until the next compare match
   always_comb begin
      hold_next = hold_reg;
      if (!pwm || !imm_en || !is_out) begin
         hold_next = 1'b0;
      end else if (trig_event) begin
         hold_next = 1'b1;
      end else if (match) begin
         hold_next = 1'b0;
      end
      raw_next = raw_reg;
      unique case (oc_code)
         OC_OFF:   raw_next = raw_reg;
         OC_HI_M:  raw_next = match ? 1'b1 : raw_reg;
         OC_LO_M:  raw_next = match ? 1'b0 : raw_reg;
         OC_TOG:   raw_next = match ? ~raw_reg : raw_reg;
         OC_F_LO:  raw_next = 1'b0;
         OC_F_HI:  raw_next = 1'b1;
         OC_PWM_A: raw_next = hold_next ? 1'b1 : pwm_a_lvl;
         OC_PWM_B: raw_next = hold_next ? 1'b0 : ~pwm_a_lvl;
      endcase
   end

   // enabled output channel with a connected code follows raw xor polarity
   always_comb begin
      if (ch_en && is_out && (oc_code != OC_OFF)) begin
         out_next = raw_next ^ pol;
      end else begin
         out_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         raw_reg  <= 1'b0;
         hold_reg <= 1'b0;
         out_reg  <= 1'b0;
      end else begin
         raw_reg  <= raw_next;
         hold_reg <= hold_next;
         out_reg  <= out_next;
      end
   end

   // read port, data valid the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_next = '0;
      if (rd_stb) begin
         unique case (addr)
            ADDR_MODE: rdata_next[MODE_W-1:0] = mode_reg;
            ADDR_CTRL: rdata_next[3:0] = ctrl_reg;
            ADDR_DATA: rdata_next = active_reg;
            ADDR_STAT: begin
               rdata_next[STAT_RAW]            = raw_reg;
               rdata_next[STAT_FILT]           = filt_level;
               rdata_next[STAT_CNT_LO +: 3]    = psc_cnt_reg;
            end
            default:   rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_reg <= DATA_RST;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata         = rdata_reg;
   assign ch1_output    = out_reg;
   assign capture_pulse = cap_reg;

endmodule // tcm_channel

`default_nettype wire

// *** dv/tcm_pin_model.sv ***
// model of the channel pin source at the far side of the block
`timescale 1ns/100ps
`default_nettype none

module tcm_pin_model (
   // clock
   input  wire logic mclk,
   // level asked for by the bench
   input  wire logic req_lvl,
   // pin
   output var  logic ch1_input
);
   // push-pull source, so the pin never floats; moves only after an edge
   always @(posedge mclk) ch1_input <= req_lvl;
endmodule // tcm_pin_model

`default_nettype wire

// *** dv/tcm_channel_chk.sv ***
// port-level assertions for the timer channel mode block
`timescale 1ns/100ps
`default_nettype none

module tcm_channel_chk
   import tcm_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              arst_n,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   input  wire logic [DATA_W-1:0] rdata,
   // counter side
   input  wire logic [DATA_W-1:0] cnt_value,
   input  wire logic              cnt_down,
   input  wire logic              ovf_event,
   input  wire logic              trig_event,
   // pins and capture result
   input  wire logic              ch1_input,
   input  wire logic              ch1_output,
   input  wire logic              capture_pulse
);
   logic [7:0]        mode_q;
   logic [3:0]        ctrl_q;
   logic [DATA_W-1:0] act_q;
   logic [DATA_W-1:0] shd_q;
   logic              out_en;
   logic              pwm_hi;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // register copies; act_q is only trusted while the channel is an output
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= MODE_RST;
         ctrl_q <= CTRL_RST;
         act_q  <= DATA_RST;
         shd_q  <= DATA_RST;
      end else begin
         if (wr_stb && addr == ADDR_MODE) mode_q <= wdata[7:0];
         if (wr_stb && addr == ADDR_CTRL) ctrl_q <= wdata[3:0];
         if (wr_stb && addr == ADDR_DATA) shd_q <= wdata;
         if (wr_stb && addr == ADDR_DATA && !mode_q[MODE_PRE]) act_q <= wdata;
         else if (ovf_event && mode_q[MODE_PRE]) act_q <= shd_q;
      end
   end

   // compare view decode
   assign out_en = ctrl_q[CTRL_EN] && mode_q[1:0] == DIR_OUT;
   assign pwm_hi = act_q > cnt_value;

   sequence s_imm_trig;
      out_en && mode_q[6:4] == OC_PWM_A && mode_q[MODE_IMM] && !ctrl_q[CTRL_POL]
         && trig_event && !pwm_hi && cnt_value != act_q;
   endsequence
   sequence s_off2;
      !ctrl_q[CTRL_EN] [*2];
   endsequence

   AST_EN_LOW: assert property (!ctrl_q[CTRL_EN] |=> !ch1_output)
      else $error("output not low while disabled");
   AST_OFF_LOW: assert property (out_en && mode_q[6:4] == OC_OFF |=> !ch1_output)
      else $error("output not low with code 000");
   AST_RSV_LOW: assert property (mode_q[1] |=> !ch1_output)
      else $error("output driven in reserved direction");
   AST_MATCH_HI: assert property (out_en && !ctrl_q[CTRL_POL] && mode_q[6:4] == OC_HI_M
      && cnt_value == act_q |=> ch1_output) else $error("no high on compare match");
   AST_FORCE: assert property (out_en && mode_q[6:5] == 2'b10
      |=> ch1_output == ($past(mode_q[4]) ^ $past(ctrl_q[CTRL_POL])))
      else $error("forced level wrong");
   AST_PWM_CMP: assert property (out_en && mode_q[6:4] == OC_PWM_A && !mode_q[MODE_IMM]
      && !cnt_down && !ctrl_q[CTRL_POL] |=> ch1_output == $past(pwm_hi))
      else $error("pwm level not from compare");
   AST_IMM: assert property (s_imm_trig |-> ##[1:2] ch1_output)
      else $error("trigger did not force output");
   AST_CAP_OFF: assert property (s_off2 |-> !capture_pulse)
      else $error("capture while disabled");
   AST_CAP_OUT: assert property ((mode_q[1:0] == DIR_OUT) [*3] |-> !capture_pulse)
      else $error("capture in output mode");
   AST_CAP_ONE: assert property (capture_pulse |=> !capture_pulse)
      else $error("capture pulse too long");
endmodule // tcm_channel_chk

bind tcm_channel tcm_channel_chk u_chk (.mclk(mclk), .arst_n(arst_n), .addr(addr),
   .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cnt_value(cnt_value),
   .cnt_down(cnt_down), .ovf_event(ovf_event), .trig_event(trig_event),
   .ch1_input(ch1_input), .ch1_output(ch1_output), .capture_pulse(capture_pulse));

`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the timer channel mode block
`timescale 1ns/100ps
`default_nettype none

module testbench
   import tcm_pkg::*;
;
   logic              mclk;
   logic              arst_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr_stb;
   logic              rd_stb;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] cnt_value;
   logic              cnt_down;
   logic              ovf_event;
   logic              trig_event;
   logic              ch1_input;
   logic              ch1_output;
   logic              capture_pulse;
   logic              pin_lvl;
   logic [DATA_W-1:0] got;
   int                err_count = 0;
   int                check_count = 0;
   int                cap_cnt = 0;
   // run length and base clock divide for each filter code
   int                fn [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
   int                fd [16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};

   tcm_channel #(.DTS_DIV(1)) DUT (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cnt_value(cnt_value),
      .cnt_down(cnt_down), .ovf_event(ovf_event), .trig_event(trig_event),
      .ch1_input(ch1_input), .ch1_output(ch1_output), .capture_pulse(capture_pulse));
   tcm_pin_model u_pin (.mclk(mclk), .req_lvl(pin_lvl), .ch1_input(ch1_input));

   // 40 MHz clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // count every capture pulse; scenarios compare differences
   always @(posedge mclk) if (capture_pulse === 1'b1) cap_cnt <= cap_cnt + 1;

   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask
   // one-cycle strobes, launched and dropped just after edges
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      @(posedge mclk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1;
      got = rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic cnt(input logic [DATA_W-1:0] v);
      @(posedge mclk);
      cnt_value <= v;
   endtask
   // one-cycle counter event: trigger when t is set, else overflow
   task automatic ev(input logic t);
      @(posedge mclk);
      trig_event <= t;
      ovf_event  <= !t;
      @(posedge mclk);
      trig_event <= 1'b0;
      ovf_event  <= 1'b0;
   endtask
   function automatic logic [DATA_W-1:0] om(input logic [2:0] oc, input logic pre, imm);
      return {8'h00, 1'b0, oc, pre, imm, DIR_OUT};
   endfunction
   // bounded wait for a capture; running out ends the run
   task automatic wait_cap(input int lim, output int n);
      n = 0;
      while (capture_pulse !== 1'b1) begin
         if (n >= lim) begin
            chk(16'h0000, 16'h0001);
            finish_test();
         end
         cyc(1);
         n++;
      end
   endtask
   task automatic pulses(input int k);
      repeat (k) begin
         @(posedge mclk);
         pin_lvl <= 1'b1;
         repeat (8) @(posedge mclk);
         pin_lvl <= 1'b0;
         repeat (8) @(posedge mclk);
      end
      cyc(4);
   endtask

   task automatic t_regs();
      rd(ADDR_MODE); chk(got, 16'h0000);
      rd(ADDR_CTRL); chk(got, 16'h0000);
      rd(ADDR_DATA); chk(got, 16'h0000);
      wr(ADDR_MODE, 16'hFFFF);
      rd(ADDR_MODE); chk(got, 16'h00FF);
      wr(4'h2, 16'hA5A5);
      rd(4'h2); chk(got, 16'h0000);
      wr(ADDR_MODE, om(OC_F_LO, 1'b0, 1'b0)); // known low raw level
   endtask
   task automatic t_preload();
      cnt(16'h0005);
      wr(ADDR_MODE, om(OC_HI_M, 1'b0, 1'b0));
      wr(ADDR_CTRL, 16'h0001);
      wr(ADDR_DATA, 16'h0010);
      rd(ADDR_DATA); chk(got, 16'h0010);
      cyc(2); chkb(ch1_output, 1'b0);
      cnt(16'h0010);
      cyc(2); chkb(ch1_output, 1'b1);
      wr(ADDR_MODE, om(OC_HI_M, 1'b1, 1'b0));
      wr(ADDR_DATA, 16'h0020);
      rd(ADDR_DATA); chk(got, 16'h0010);
      ev(1'b0);
      rd(ADDR_DATA); chk(got, 16'h0020);
   endtask
   task automatic t_force();
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_MODE, om({2'b10, i[0]}, 1'b0, 1'b0));
         wr(ADDR_CTRL, {14'h0000, i[1], 1'b1});
         cyc(2); chkb(ch1_output, i[0] ^ i[1]);
      end
      wr(ADDR_CTRL, 16'h0000);
      cyc(2); chkb(ch1_output, 1'b0);
      wr(ADDR_CTRL, 16'h0001);
      cyc(2); chkb(ch1_output, 1'b1);
      wr(ADDR_MODE, om(OC_OFF, 1'b0, 1'b0));
      cyc(2); chkb(ch1_output, 1'b0);
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_MODE, 16'h0052);
      wr(ADDR_CTRL, 16'h0001);
      cyc(2); chkb(ch1_output, 1'b0);
      wr(ADDR_CTRL, 16'h0000);
   endtask
   task automatic t_pwm();
      wr(ADDR_MODE, om(OC_PWM_A, 1'b0, 1'b0));
      wr(ADDR_CTRL, 16'h0001);
      wr(ADDR_DATA, 16'h0040);
      cnt(16'h0030);
      cyc(2); chkb(ch1_output, 1'b1);
      cnt(16'h0050);
      cyc(2); chkb(ch1_output, 1'b0);
      wr(ADDR_MODE, om(OC_PWM_A, 1'b0, 1'b1));
      cyc(2); chkb(ch1_output, 1'b0);
      ev(1'b1);
      cyc(2); chkb(ch1_output, 1'b1);
      cnt(16'h0040);
      cyc(3); chkb(ch1_output, 1'b0);
      wr(ADDR_MODE, om(OC_PWM_A, 1'b0, 1'b0));
      // down count: high while compare value is not below the count
      cnt_down <= 1'b1;
      cyc(2); chkb(ch1_output, 1'b1);
      cnt(16'h0050);
      cyc(2); chkb(ch1_output, 1'b0);
      @(posedge mclk);
      cnt_down <= 1'b0;
   endtask
   // a run one sample short must be swallowed, a full run must pass in time
   task automatic t_filter();
      int n;
      int w;
      for (int c = 0; c < 16; c++) begin
         wr(ADDR_CTRL, 16'h0000);
         wr(ADDR_MODE, 16'(c * 16 + 1));
         wr(ADDR_CTRL, 16'h000B);
         cyc(fn[c] * fd[c] + 8);
         @(posedge mclk);
         pin_lvl <= ~pin_lvl;
         wait_cap(fn[c] * fd[c] + 12, n);
         chkb(n >= (fn[c] - 1) * fd[c], 1'b1);
         cyc(1);
         w = cap_cnt;
         if (c > 0) begin
            @(posedge mclk);
            pin_lvl <= ~pin_lvl;
            repeat ((fn[c] - 1) * fd[c]) @(posedge mclk);
            pin_lvl <= ~pin_lvl;
            cyc(fn[c] * fd[c] + 12);
            chk(16'(cap_cnt), 16'(w));
         end
      end
   endtask
   // one edge sense per pass, odd passes falling; the other sense must not count
   task automatic t_psc();
      int c0;
      cnt(16'h1234);
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_CTRL, 16'h0000);
         wr(ADDR_MODE, 16'(p * 4 + 1));
         wr(ADDR_CTRL, {14'h0000, p[0], 1'b1});
         c0 = cap_cnt;
         pulses(3);
         rd(ADDR_STAT); chk((got >> 2) & 16'h0007, 16'(3 % (1 << p)));
         pulses(5);
         chk(16'(cap_cnt - c0), 16'(8 >> p));
         pulses(1);
         wr(ADDR_CTRL, 16'h0000);
         rd(ADDR_STAT); chk((got >> 2) & 16'h0007, 16'h0000);
      end
      rd(ADDR_DATA); chk(got, 16'h1234);
   endtask

   // reset, then the scenarios in order: output views before input views
   initial begin
      arst_n     = 1'b0;
      addr       = '0;
      wdata      = '0;
      wr_stb     = 1'b0;
      rd_stb     = 1'b0;
      cnt_value  = '0;
      cnt_down   = 1'b0;
      ovf_event  = 1'b0;
      trig_event = 1'b0;
      pin_lvl    = 1'b0;
      repeat (12) @(posedge mclk);
      arst_n <= 1'b1;
      t_regs();
      t_preload();
      t_force();
      t_pwm();
      t_filter();
      t_psc();
      finish_test();
   end
endmodule // testbench

`default_nettype wire
